// ### design/cfv_pkg.sv
// package for the processor flag and interrupt vector clear block
// assumes one 100 MHz system clock and a 32-bit apb register bus
package cfv_pkg;

  // ==========================================================
  // register indices and byte addresses (byte = 4 * index)
  localparam logic [7:0]  IDX_VECTOR_CLEAR  = 8'he2;  // interrupt_vector_clear
  localparam logic [7:0]  IDX_FLAGS         = 8'hf7;  // processor_flags
  localparam logic [7:0]  IDX_INT_MASK      = 8'h40;  // source mask register
  localparam logic [11:0] ADDR_VECTOR_CLEAR = {2'h0, IDX_VECTOR_CLEAR, 2'h0};
  localparam logic [11:0] ADDR_FLAGS        = {2'h0, IDX_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_INT_MASK     = {2'h0, IDX_INT_MASK, 2'h0};

  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_FLAGS         = 8'h00;
  localparam logic [7:0]  RST_VECTOR        = 8'h00;
  localparam logic [7:0]  RST_INT_MASK      = 8'h00;

  // ==========================================================
  // flag register field positions
  localparam int          PGM_HI            = 7;  // page_addressing_mode msb
  localparam int          PGM_LO            = 6;  // page_addressing_mode lsb
  localparam int          BIT_UNCONNECTED   = 5;  // unconnected_flag_bit
  localparam int          BIT_EXT_SPACE     = 4;  // extended_space_select
  localparam int          BIT_RESERVED      = 3;  // always reads zero
  localparam int          BIT_CARRY         = 2;
  localparam int          BIT_ZERO          = 1;
  localparam int          BIT_GIE           = 0;  // global_interrupt_enable
  localparam logic [7:0]  FLAGS_WMASK       = 8'hf7;  // writable bits

  // ==========================================================
  // vector step between sources; vector 0 means nothing pending
  localparam logic [7:0]  VECTOR_STEP       = 8'h04;

  // ==========================================================
  // page addressing modes
  typedef enum logic [1:0] {
    CFV_PG_ZERO    = 2'b00,  // both operands on page 0
    CFV_PG_STACK   = 2'b01,  // direct page 0, indexed stack page
    CFV_PG_INDEX   = 2'b10,  // direct current, indexed index page
    CFV_PG_CUR_STK = 2'b11   // direct current, indexed stack page
  } cfv_page_addressing_mode_e;

  // flag instructions the core executes
  typedef enum logic [1:0] {
    CFV_OP_AND = 2'b00,
    CFV_OP_OR  = 2'b01,
    CFV_OP_XOR = 2'b10
  } cfv_flag_op_e;

endpackage

// ### design/cfv_page_sel.sv
// ram page selection for direct and indexed operands
// assumes page pointers come from same-clock core logic
`timescale 1ns/100ps
module cfv_page_sel #(
  parameter int PAGE_W = 8
) (
  input  wire logic [1:0]        mode_i,        // page_addressing_mode
  input  wire logic [PAGE_W-1:0] cur_page_i,    // current_page_pointer
  input  wire logic [PAGE_W-1:0] idx_page_i,    // index_page_pointer
  input  wire logic [PAGE_W-1:0] stk_page_i,    // stack_page_pointer
  output logic      [PAGE_W-1:0] direct_page_o,
  output logic      [PAGE_W-1:0] indexed_page_o
);

  // ==========================================================
  // mode decode, purely combinational so the core sees it at once
  always_comb begin
    unique case (cfv_pkg::cfv_page_addressing_mode_e'(mode_i))
      cfv_pkg::CFV_PG_ZERO: begin
        direct_page_o  = '0;
        indexed_page_o = '0;
      end
      cfv_pkg::CFV_PG_STACK: begin
        direct_page_o  = '0;
        indexed_page_o = stk_page_i;
      end
      cfv_pkg::CFV_PG_INDEX: begin
        direct_page_o  = cur_page_i;
        indexed_page_o = idx_page_i;
      end
      cfv_pkg::CFV_PG_CUR_STK: begin
        direct_page_o  = cur_page_i;
        indexed_page_o = stk_page_i;
      end
    endcase
  end

endmodule

// ### design/cfv_int_ctrl.sv
// posted and pending interrupt state with priority vector
// assumes source requests are one-cycle pulses from same-clock logic
`timescale 1ns/100ps
module cfv_int_ctrl #(
  parameter int N_SRC = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [N_SRC-1:0] irq_i,        // source events
  input  wire logic [N_SRC-1:0] mask_i,       // 1 lets a posted source pend
  input  wire logic             clear_all_i,  // drop every posted request
  input  wire logic             ack_i,        // core took the top vector
  output logic      [N_SRC-1:0] posted_o,
  output logic      [N_SRC-1:0] pending_o,
  output logic      [7:0]       vector_o      // 0 when nothing pends
);

  logic [N_SRC-1:0] posted_r;    // posted requests
  logic [N_SRC-1:0] posted_nxt;
  logic [N_SRC-1:0] top_onehot;  // highest priority pending source

  // ==========================================================
  // masking gates pending only; posting carries on regardless
  assign pending_o = posted_r & mask_i;
  assign posted_o  = posted_r;

  // ==========================================================
  // priority: lowest source number wins
  always_comb begin
    top_onehot = '0;
    vector_o   = cfv_pkg::RST_VECTOR;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (pending_o[i]) begin
        top_onehot    = '0;
        top_onehot[i] = 1'b1;
        vector_o      = 8'((i + 1) * cfv_pkg::VECTOR_STEP);
      end
    end
  end

  // ==========================================================
  // per-source next state: a new event wins over any clear
  generate
    for (genvar g = 0; g < N_SRC; g++) begin : g_src
      always_comb begin
        if (irq_i[g]) begin
          posted_nxt[g] = 1'b1;
        end else if (clear_all_i || (ack_i && top_onehot[g])) begin
          posted_nxt[g] = 1'b0;
        end else begin
          posted_nxt[g] = posted_r[g];
        end
      end
    end
  endgenerate

  // register stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      posted_r <= '0;
    end else begin
      posted_r <= posted_nxt;
    end
  end

endmodule

// ### design/cfv_flags_vc.sv
// processor flag register and interrupt vector clear register
// assumes an apb master on clk_i and a core on the same clock
`timescale 1ns/100ps
module cfv_flags_vc #(
  parameter int N_SRC  = 8,
  parameter int PAGE_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // core flag operations
  input  wire logic              flag_op_valid_i,  // flag instruction this cycle
  input  wire logic [1:0]        flag_op_i,        // and / or / xor
  input  wire logic [7:0]        flag_operand_i,   // instruction immediate
  input  wire logic              alu_update_i,     // alu result valid
  input  wire logic              alu_carry_i,
  input  wire logic              alu_zero_i,
  input  wire logic              isr_entry_i,      // core enters service routine
  // page pointers
  input  wire logic [PAGE_W-1:0] current_page_pointer_i,
  input  wire logic [PAGE_W-1:0] index_page_pointer_i,
  input  wire logic [PAGE_W-1:0] stack_page_pointer_i,
  // interrupt sources
  input  wire logic [N_SRC-1:0]  irq_i,
  // outputs to the core
  output logic      [7:0]        flags_o,
  output logic      [PAGE_W-1:0] direct_page_o,
  output logic      [PAGE_W-1:0] indexed_page_o,
  output logic                   extended_space_select_o,
  output logic                   global_interrupt_enable_o,
  output logic                   int_req_o,        // pending and enabled
  output logic      [7:0]        int_vector_o      // vector for the core
);

  // ==========================================================
  // declarations
  logic [7:0]       flags_r;      // processor_flags
  logic [7:0]       flags_nxt;
  logic [7:0]       op_result;    // flag instruction result
  logic [N_SRC-1:0] mask_r;       // source mask
  logic [N_SRC-1:0] mask_nxt;
  logic [31:0]      prdata_r;     // read data, captured in setup
  logic [31:0]      prdata_nxt;
  logic             pslverr_r;    // unmapped address seen in setup
  logic             pslverr_nxt;
  logic             setup;        // apb setup cycle
  logic             access;       // apb access cycle (always ready)
  logic             hit_vc;       // address decodes
  logic             hit_flags;
  logic             hit_mask;
  logic             vc_write;     // clears the controller
  logic             int_ack;      // core takes a vector
  logic [N_SRC-1:0] pending;
  logic [N_SRC-1:0] posted;       // posted requests, watched by assertions
  logic [7:0]       vector;

  // ==========================================================
  // apb decode; zero wait states keep the bus cycle at two clocks
  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign hit_vc    = (paddr == cfv_pkg::ADDR_VECTOR_CLEAR);
  assign hit_flags = (paddr == cfv_pkg::ADDR_FLAGS);
  assign hit_mask  = (paddr == cfv_pkg::ADDR_INT_MASK);
  assign pready    = 1'b1;
  assign prdata    = prdata_r;
  assign pslverr   = access && pslverr_r;
  assign vc_write  = access && pwrite && hit_vc;

  // ==========================================================
  // interrupt controller; the core acknowledges on service entry
  // a level source that is still high reposts at once after the
  // acknowledge, so the core sees it again when it leaves the routine
  assign int_ack   = isr_entry_i;

  cfv_int_ctrl #(
    .N_SRC (N_SRC)
  ) u_int (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .irq_i       (irq_i),
    .mask_i      (mask_r),
    .clear_all_i (vc_write),
    .ack_i       (int_ack),
    .posted_o    (posted),
    .pending_o   (pending),
    .vector_o    (vector)
  );

  // gie gates delivery only, never posting or pending
  assign int_req_o    = flags_r[cfv_pkg::BIT_GIE] && (|pending);
  assign int_vector_o = vector;

  // ==========================================================
  // page selection from the mode field
  cfv_page_sel #(
    .PAGE_W (PAGE_W)
  ) u_page (
    .mode_i         (flags_r[cfv_pkg::PGM_HI:cfv_pkg::PGM_LO]),
    .cur_page_i     (current_page_pointer_i),
    .idx_page_i     (index_page_pointer_i),
    .stk_page_i     (stack_page_pointer_i),
    .direct_page_o  (direct_page_o),
    .indexed_page_o (indexed_page_o)
  );

  assign flags_o                   = flags_r;
  assign extended_space_select_o   = flags_r[cfv_pkg::BIT_EXT_SPACE];
  assign global_interrupt_enable_o = flags_r[cfv_pkg::BIT_GIE];

  // ==========================================================
  // flag instruction datapath
  always_comb begin
    unique case (flag_op_i)
      cfv_pkg::CFV_OP_AND: op_result = flags_r & flag_operand_i;
      cfv_pkg::CFV_OP_OR:  op_result = flags_r | flag_operand_i;
      cfv_pkg::CFV_OP_XOR: op_result = flags_r ^ flag_operand_i;
      default:             op_result = flags_r;  // illegal code: no change
    endcase
  end

  // ==========================================================
  // flag next state: service entry beats instructions beats alu
  // apb writes never reach here, so the bus cannot corrupt flags
  always_comb begin
    flags_nxt = flags_r;
    if (isr_entry_i) begin
      flags_nxt = cfv_pkg::RST_FLAGS;
    end else if (flag_op_valid_i) begin
      // bit 5 is plain storage; reserved bit forced low
      flags_nxt = op_result & cfv_pkg::FLAGS_WMASK;
    end else if (alu_update_i) begin
      flags_nxt[cfv_pkg::BIT_CARRY] = alu_carry_i;
      flags_nxt[cfv_pkg::BIT_ZERO]  = alu_zero_i;
    end
  end

  // ==========================================================
  // mask register next state
  // the mask register is local to this block; only N_SRC bits are kept
  always_comb begin
    mask_nxt = mask_r;
    if (access && pwrite && hit_mask) begin
      mask_nxt = pwdata[N_SRC-1:0];
    end
  end

  // ==========================================================
  // read data and error captured in setup; the vector is a snapshot
  always_comb begin
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup) begin
      prdata_nxt  = '0;
      pslverr_nxt = !(hit_vc || hit_flags || hit_mask);
      if (!pwrite) begin
        if (hit_vc) begin
          prdata_nxt[7:0] = vector;
        end else if (hit_flags) begin
          prdata_nxt[7:0] = flags_r;
        end else if (hit_mask) begin
          prdata_nxt[N_SRC-1:0] = mask_r;
        end
      end
    end
  end

  // ==========================================================
  // register stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_r   <= cfv_pkg::RST_FLAGS;
      mask_r    <= N_SRC'(cfv_pkg::RST_INT_MASK);
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else begin
      flags_r   <= flags_nxt;
      mask_r    <= mask_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ==========================================================
  // assertions; every attempt is dropped while reset is low, so a
  // mid-run reset cannot leave a half-checked property behind
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  AST_VC_READ: assert property (
    setup && !pwrite && hit_vc |=> prdata[7:0] == $past(vector) && prdata[31:8] == '0)
    else $error("vector read data wrong");

  AST_VC_CLEAR: assert property (
    vc_write && !(|irq_i) |=> posted == '0 ##1 ($past(irq_i) != '0 || $stable(pending)))
    else $error("vector write did not clear pending");

  AST_FLAGS_HOLD: assert property (
    !isr_entry_i && !flag_op_valid_i && !alu_update_i |=> $stable(flags_r))
    else $error("flags changed without a cause");

  AST_FLAGS_XOR: assert property (
    !isr_entry_i && flag_op_valid_i && flag_op_i == 2'b10
    |=> flags_r == (($past(flags_r) ^ $past(flag_operand_i)) & 8'hf7))
    else $error("xor flag instruction wrong");

  AST_FLAGS_OR: assert property (
    !isr_entry_i && flag_op_valid_i && flag_op_i == 2'b01
    |=> flags_r == (($past(flags_r) | $past(flag_operand_i)) & cfv_pkg::FLAGS_WMASK))
    else $error("or flag instruction wrong");

  AST_FLAGS_AND: assert property (
    !isr_entry_i && flag_op_valid_i && flag_op_i == 2'b00
    |=> flags_r == (($past(flags_r) & $past(flag_operand_i)) & cfv_pkg::FLAGS_WMASK))
    else $error("and flag instruction wrong");

  AST_FLAGS_NOP: assert property (
    !isr_entry_i && flag_op_valid_i && flag_op_i == 2'b11 |=> $stable(flags_r))
    else $error("unused flag op changed flags");

  AST_PAGE_ZERO: assert property (
    flags_r[7:6] == 2'b00 |-> direct_page_o == '0 && indexed_page_o == '0)
    else $error("page mode zero not on page 0");

  AST_ISR_CLEAR: assert property (
    isr_entry_i |=> flags_r == 8'h00 && !global_interrupt_enable_o)
    else $error("flags not cleared on service entry");

  AST_PAGE_ONE: assert property (
    flags_r[7:6] == 2'b01 |-> direct_page_o == '0 && indexed_page_o == stack_page_pointer_i)
    else $error("page mode one wrong");

  AST_PAGE_CUR: assert property (
    flags_r[7] |-> direct_page_o == current_page_pointer_i
      && indexed_page_o == (flags_r[6] ? stack_page_pointer_i : index_page_pointer_i))
    else $error("current page modes wrong");

  AST_CARRY_ZERO: assert property (
    alu_update_i && !flag_op_valid_i && !isr_entry_i
    |=> flags_r[2] == $past(alu_carry_i) && flags_r[1] == $past(alu_zero_i))
    else $error("carry or zero not recorded");

  AST_GIE_GATE: assert property (
    !flags_r[0] |-> !int_req_o)
    else $error("interrupt request with gie low");

  AST_INT_REQ: assert property (
    flags_r[cfv_pkg::BIT_GIE] && (|pending) |-> int_req_o)
    else $error("no request with gie high and a source pending");

  AST_RESERVED: assert property (
    flags_r[3] == 1'b0)
    else $error("reserved flag bit set");

  AST_MASKED: assert property (
    (pending & ~mask_r) == '0)
    else $error("masked source pending");

  AST_MASKED_POSTS: assert property (
    (|irq_i) |=> (posted & $past(irq_i)) == $past(irq_i))
    else $error("source event did not post");

  AST_VEC_EMPTY: assert property (
    pending == '0 |-> vector == cfv_pkg::RST_VECTOR)
    else $error("vector not zero with nothing pending");

  AST_VEC_TWO: assert property (
    pending[1:0] == 2'b10 |-> vector == 8'(2 * cfv_pkg::VECTOR_STEP))
    else $error("vector of source 1 wrong");

  AST_UNMAPPED: assert property (
    access && !(hit_vc || hit_flags || hit_mask) |-> pslverr)
    else $error("unmapped access without error");

  COV_VC_CLEAR: cover property (vc_write && (|pending));
  COV_ISR_ENTRY: cover property (int_req_o ##1 isr_entry_i);
  COV_PAGE_CUR_STK: cover property (flags_r[7:6] == 2'b11);
  COV_UNMAPPED: cover property (pslverr);
  COV_MASKED_POST: cover property (|(posted & ~mask_r));

endmodule

// ### testbench/cfv_core_model.sv
// ==========================================================
// core model: issues flag instructions, alu results and
// service routine entry toward the flag register block
// assumes a same-clock core; tasks are called from the bench
`timescale 1ns/100ps
module cfv_core_model (
  input  wire logic       clk_i,
  output logic            flag_op_valid_o,  // one-cycle flag instruction
  output logic      [1:0] flag_op_o,        // and / or / xor / unused
  output logic      [7:0] flag_operand_o,   // instruction immediate
  output logic            alu_update_o,     // alu result strobe
  output logic            alu_carry_o,
  output logic            alu_zero_o,
  output logic            isr_entry_o       // service routine entry
);
  // idle values at time zero
  initial begin
    flag_op_valid_o = 1'b0;
    flag_op_o       = 2'h0;
    flag_operand_o  = 8'h00;
    alu_update_o    = 1'b0;
    alu_carry_o     = 1'b0;
    alu_zero_o      = 1'b0;
    isr_entry_o     = 1'b0;
  end

  // ==========================================================
  // flag instruction: reserved bit always written as zero
  task automatic flag_op(input logic [1:0] op, input logic [7:0] operand);
    @(posedge clk_i);
    flag_op_valid_o <= 1'b1;
    flag_op_o       <= op;
    flag_operand_o  <= operand & 8'hf7;
    @(posedge clk_i);
    flag_op_valid_o <= 1'b0;
    // released immediate does not keep its last value
    flag_operand_o  <= ~(operand & 8'hf7);
  endtask

  // ==========================================================
  // alu result of the last logical or arithmetic operation
  task automatic alu_result(input logic carry, input logic zero);
    @(posedge clk_i);
    alu_update_o <= 1'b1;
    alu_carry_o  <= carry;
    alu_zero_o   <= zero;
    @(posedge clk_i);
    alu_update_o <= 1'b0;
    alu_carry_o  <= ~carry;
    alu_zero_o   <= ~zero;
  endtask

  // ==========================================================
  // service routine entry, also acknowledges the top source
  task automatic isr_entry();
    @(posedge clk_i);
    isr_entry_o <= 1'b1;
    @(posedge clk_i);
    isr_entry_o <= 1'b0;
  endtask
endmodule

// ### testbench/tb_top.sv
// ==========================================================
// self-checking bench for the flag and vector clear block
// assumes zero-wait apb slave and the core model beside it
`timescale 1ns/100ps
module tb_top;
  // row of the flag instruction table
  typedef struct {
    logic [1:0] op;
    logic [7:0] operand;
    logic [7:0] flags;
  } cfv_row_s;

  localparam logic [7:0] CUR_PG = 8'h11;  // distinct pointers expose mux slips
  localparam logic [7:0] IDX_PG = 8'h22;
  localparam logic [7:0] STK_PG = 8'h33;

  logic        clk_i, rstn_i, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic        fv, au, ac, az, ie;
  logic [1:0]  fop;
  logic [7:0]  fopnd, irq, flags, dpg, ipg, vec;
  logic        ext, global_interrupt_enable, ireq;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch, num_checks;
  cfv_row_s    rows[7];

  cfv_core_model u_cfv_core_model (.clk_i(clk_i), .flag_op_valid_o(fv), .flag_op_o(fop),
    .flag_operand_o(fopnd), .alu_update_o(au), .alu_carry_o(ac), .alu_zero_o(az), .isr_entry_o(ie));

  cfv_flags_vc #(.N_SRC(8), .PAGE_W(8)) u_cfv_flags_vc (.clk_i(clk_i), .rstn_i(rstn_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flag_op_valid_i(fv), .flag_op_i(fop),
    .flag_operand_i(fopnd), .alu_update_i(au), .alu_carry_i(ac), .alu_zero_i(az),
    .isr_entry_i(ie), .current_page_pointer_i(CUR_PG), .index_page_pointer_i(IDX_PG),
    .stack_page_pointer_i(STK_PG), .irq_i(irq), .flags_o(flags), .direct_page_o(dpg),
    .indexed_page_o(ipg), .extended_space_select_o(ext), .global_interrupt_enable_o(global_interrupt_enable),
    .int_req_o(ireq), .int_vector_o(vec));

  // ==========================================================
  // clock, 10 ns period
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================
  // compare tasks, one per kind of result
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // ==========================================================
  // apb master: holds the request until pready is seen high or 50 cycles pass
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk_bit(1'b0, 1'b1, "apb pready never came");
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~wdata;  // released data does not linger
  endtask

  // page the core should see for each addressing mode
  function automatic logic [7:0] exp_dir(input logic [1:0] m);
    return (m[1] == 1'b1) ? CUR_PG : 8'h00;
  endfunction

  function automatic logic [7:0] exp_idx(input logic [1:0] m);
    return (m == 2'b00) ? 8'h00 : ((m == 2'b10) ? IDX_PG : STK_PG);
  endfunction

  task automatic pulse_irq(input logic [7:0] v);
    @(posedge clk_i);
    irq <= v;
    @(posedge clk_i);
    irq <= 8'h00;
  endtask

  // ==========================================================
  // verdict, the single place the run ends
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    rstn_i = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq = 8'h00;
    // every page mode, flag bits 7 to 4 and 0 (carry and zero stay low), and the unused op code
    rows = '{'{2'b01, 8'h01, 8'h01}, '{2'b01, 8'h40, 8'h41}, '{2'b10, 8'hc0, 8'h81},
             '{2'b01, 8'h70, 8'hf1}, '{2'b00, 8'h3f, 8'h31}, '{2'b10, 8'h11, 8'h20},
             '{2'b11, 8'hff, 8'h20}};
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    foreach (rows[i]) begin
      u_cfv_core_model.flag_op(rows[i].op, rows[i].operand);
      #1;
      chk_byte(flags, rows[i].flags, "flags_o");
      chk_byte(dpg, exp_dir(rows[i].flags[7:6]), "direct page");
      chk_byte(ipg, exp_idx(rows[i].flags[7:6]), "indexed page");
      chk_bit(ext, rows[i].flags[4], "extended space");
      chk_bit(global_interrupt_enable, rows[i].flags[0], "gie");
      apb(1'b0, cfv_pkg::ADDR_FLAGS, 32'h0);
      chk_byte(rd[7:0], rows[i].flags, "flags read");
    end
    $display("test flag table done");
    // alu results set and clear carry and zero
    u_cfv_core_model.alu_result(1'b1, 1'b0);
    #1;
    chk_byte(flags, 8'h24, "carry set");
    u_cfv_core_model.alu_result(1'b0, 1'b1);
    #1;
    chk_byte(flags, 8'h22, "zero set");
    // software write to flags is ignored
    apb(1'b1, cfv_pkg::ADDR_FLAGS, 32'h000000ff);
    chk_bit(err, 1'b0, "flags write error");
    apb(1'b0, cfv_pkg::ADDR_FLAGS, 32'h0);
    chk_byte(rd[7:0], 8'h22, "flags after apb write");
    $display("test alu and write ignore done");
    // two sources pend; lowest number wins, isr acknowledges it
    apb(1'b1, cfv_pkg::ADDR_INT_MASK, 32'h000000ff);
    u_cfv_core_model.flag_op(2'b01, 8'h01);
    pulse_irq(8'h24);
    apb(1'b0, cfv_pkg::ADDR_VECTOR_CLEAR, 32'h0);
    chk_byte(rd[7:0], 8'h0c, "vector of source 2");
    chk_byte(vec, 8'h0c, "int_vector source 2");
    chk_bit(ireq, 1'b1, "int_req enabled");
    u_cfv_core_model.isr_entry();
    #1;
    chk_byte(flags, 8'h00, "flags after isr entry");
    chk_bit(ireq, 1'b0, "int_req with gie off");
    chk_byte(dpg, 8'h00, "page 0 in isr");
    apb(1'b0, cfv_pkg::ADDR_VECTOR_CLEAR, 32'h0);
    chk_byte(rd[7:0], 8'h18, "vector of source 5");
    chk_byte(vec, 8'h18, "int_vector source 5");
    // any written value clears everything
    apb(1'b1, cfv_pkg::ADDR_VECTOR_CLEAR, 32'h0000005a);
    apb(1'b0, cfv_pkg::ADDR_VECTOR_CLEAR, 32'h0);
    chk_byte(rd[7:0], 8'h00, "vector after clear");
    chk_byte(vec, 8'h00, "int_vector after clear");
    $display("test vector and clear done");
    // masked source posts, pends only once unmasked
    apb(1'b1, cfv_pkg::ADDR_INT_MASK, 32'h00000020);
    u_cfv_core_model.flag_op(2'b01, 8'h01);
    pulse_irq(8'h02);
    apb(1'b0, cfv_pkg::ADDR_VECTOR_CLEAR, 32'h0);
    chk_byte(rd[7:0], 8'h00, "masked source");
    chk_bit(ireq, 1'b0, "masked source no request");
    apb(1'b1, cfv_pkg::ADDR_INT_MASK, 32'h00000022);
    apb(1'b0, cfv_pkg::ADDR_VECTOR_CLEAR, 32'h0);
    chk_byte(rd[7:0], 8'h08, "unmasked posted source");
    chk_bit(ireq, 1'b1, "unmasked source request");
    apb(1'b1, cfv_pkg::ADDR_VECTOR_CLEAR, 32'h00000000);
    apb(1'b0, cfv_pkg::ADDR_VECTOR_CLEAR, 32'h0);
    chk_byte(rd[7:0], 8'h00, "posted dropped by clear");
    $display("test mask done");
    // unmapped address answers with an error
    apb(1'b0, 12'h200, 32'h0);
    chk_bit(err, 1'b1, "unmapped error");
    chk_byte(rd[7:0], 8'h00, "unmapped read");
    $display("test unmapped done");
    // second reset in mid-run, then reset values
    u_cfv_core_model.flag_op(2'b01, 8'hf1);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    chk_byte(flags, cfv_pkg::RST_FLAGS, "flags after reset");
    apb(1'b0, cfv_pkg::ADDR_FLAGS, 32'h0);
    chk_byte(rd[7:0], 8'h00, "flags reset read");
    apb(1'b0, cfv_pkg::ADDR_VECTOR_CLEAR, 32'h0);
    chk_byte(rd[7:0], 8'h00, "vector reset read");
    apb(1'b0, cfv_pkg::ADDR_INT_MASK, 32'h0);
    chk_byte(rd[7:0], cfv_pkg::RST_INT_MASK, "mask reset read");
    $display("test reset done");
    print_verdict();
  end
endmodule
